// ===== inc/wadm_pkg.sv
// wadm_pkg: constants, types and lane decode of the wide-to-narrow adapter
// assumes a single 100 MHz system clock shared by every user of this package
// Operation
// - narrow side sees only byte or halfword
// - aligned 32-bit memory access runs as two cycles
// - map 32-bit path to 16, drive byte enables
// - capture slave id byte, gate slave reads
// - no data buffers on mmu slave reads
// - upper address buffer off in slave, idle
// - delay buffer enables in memory writes
// - swap buffer waits until upper address off
// - slave strobe waits for valid direction
// - route mmu address valid, hold ack
package wadm_pkg;

  // widths
  localparam int ADDR_W   = 24;
  localparam int DATA_W   = 32;
  localparam int NARROW_W = 16;
  localparam int ID_W     = 8;

  // timing: delays need not be exact, least times round up
  localparam int CLK_NS       = 10;
  localparam int WR_DELAY_NS  = 20;
  localparam int SPC_DELAY_NS = 20;
  localparam int WR_DELAY_CYC  = (WR_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPC_DELAY_CYC = (SPC_DELAY_NS + CLK_NS - 1) / CLK_NS;

  // lane constants
  localparam logic [3:0] LANE_BYTE  = 4'h1;
  localparam logic [3:0] LANE_HALF  = 4'h3;
  localparam logic [3:0] LANE_NONE  = 4'h0;
  localparam logic [3:0] BE_IDLE_N  = 4'hf;
  localparam logic [ADDR_W-1:0] HALF_STEP = 24'h000002;
  localparam logic [7:0] ADDR_PAD   = 8'h00;
  localparam int HI_LANE_BIT = 1;

  // access width
  typedef enum logic [1:0] {
    SIZE_BYTE  = 2'h0,
    SIZE_HALF  = 2'h1,
    SIZE_DWORD = 2'h2
  } wadm_size_type;

  // cycle kind
  typedef enum logic [2:0] {
    KIND_MEM_RD = 3'h0,
    KIND_MEM_WR = 3'h1,
    KIND_SLV_ID = 3'h2,
    KIND_SLV_RD = 3'h3,
    KIND_SLV_WR = 3'h4
  } wadm_kind_type;

  // bus states, gray along idle-t1-t2-t3-t4
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_T1   = 3'h1,
    ST_T2   = 3'h3,
    ST_T3   = 3'h2,
    ST_T4   = 3'h6
  } wadm_state_type;

  // one request from the emulator side
  typedef struct packed {
    wadm_kind_type          kind;
    wadm_size_type          size;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      wdata;
  } wadm_req_type;

  // buffer enables toward the target, active high
  typedef struct packed {
    logic addr_hi_oe;
    logic data_lo_oe;
    logic data_hi_oe;
  } wadm_bufen_type;

  // a doubleword is carried as halfwords, never whole
  function automatic wadm_size_type eff_size(input wadm_size_type s);
    eff_size = (s == SIZE_DWORD) ? SIZE_HALF : s;
  endfunction

  // active-high lanes touched by one narrow cycle
  function automatic logic [3:0] lane_mask(input logic [1:0] a, input wadm_size_type s);
    unique case (s)
      SIZE_BYTE: lane_mask = LANE_BYTE << a;
      SIZE_HALF: lane_mask = LANE_HALF << {a[1], 1'b0};
      default:   lane_mask = LANE_NONE;
    endcase
  endfunction

endpackage

// ===== hdl/wadm_delay.sv
// wadm_delay: rise-delayed level, falls one edge after its input falls
// assumes the input is synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module wadm_delay #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // level in and delayed level out
  input  wire logic lvl_in,
  output var  logic lvl_out
);

  // refuse a delay the shift chain cannot hold
  if (DEPTH < 1) begin : g_bad_depth
    $error("wadm_delay: DEPTH must be at least 1");
  end

  // whole state in one struct
  typedef struct packed {
    logic [DEPTH-1:0] chain;
    logic             out;
  } dly_state_type;

  dly_state_type q_r;  // registered state
  dly_state_type q_nxt;  // next state

  // fill the chain while the input holds, flush at once when it drops
  always_comb begin
    q_nxt = q_r;
    if (lvl_in) begin
      q_nxt.chain = (q_r.chain << 1) | DEPTH'(1);
    end else begin
      q_nxt.chain = '0;
    end
    q_nxt.out = lvl_in & q_r.chain[DEPTH-1];
  end

  // register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign lvl_out = q_r.out;

endmodule
`default_nettype wire

// ===== hdl/wadm_top.sv
// wadm_top: makes a 32-bit multiplexed target bus look 16 bits wide
// assumes requests, target inputs and straps are synchronous to CLK_SYS
`timescale 1ns/1ps
`default_nettype none
module wadm_top #(
  parameter logic [7:0] MMU_SLAVE_ID = 8'h5a,  // arbitrary value
  parameter bit         SLAVE_ACCESS = 1'b1,   // variant with target slave access
  parameter int         WR_DELAY     = wadm_pkg::WR_DELAY_CYC,
  parameter int         SPC_DELAY    = wadm_pkg::SPC_DELAY_CYC
) (
  // clock and reset
  input  wire logic                         CLK_SYS,
  input  wire logic                         RST,
  // request from the emulator side
  input  wire logic                         REQ_VALID,
  input  wire wadm_pkg::wadm_req_type       REQ,
  output var  logic                         REQ_READY,
  // answer to the emulator side
  output var  logic                         RSP_VALID,
  output var  logic [wadm_pkg::DATA_W-1:0]  RSP_RDATA,
  // target multiplexed bus
  input  wire logic [wadm_pkg::DATA_W-1:0]  TGT_AD_I,
  output var  logic [wadm_pkg::DATA_W-1:0]  TGT_AD_O,
  output var  logic                         TGT_AD_OE,
  output var  logic [3:0]                   BYTE_LANE_ENABLE_N,
  output var  wadm_pkg::wadm_bufen_type     BUF_EN,
  // slave handshake
  input  wire logic                         DATA_DIRECTION_IN,
  output var  logic                         SLAVE_PROCESSOR_STROBE,
  // strobe and hold routing
  input  wire logic                         MMU_ROUTE,
  input  wire logic                         PHYSICAL_ADDRESS_VALID_N,
  input  wire logic                         MMU_HOLD_ACK_OUT,
  input  wire logic                         EMU_HOLD_ACK,
  output var  logic                         CPU_ADDRESS_STROBE_N,
  output var  logic                         CPU_HOLD_ACKNOWLEDGE
);

  // refuse delays the delay lines cannot serve
  if (WR_DELAY < 1 || SPC_DELAY < 1) begin : g_bad_delay
    $error("wadm_top: delays must be at least one cycle");
  end

  // whole state in one struct
  typedef struct packed {
    wadm_pkg::wadm_state_type     st;
    wadm_pkg::wadm_req_type       req;
    logic                         second;   // on second half of a doubleword
    logic [wadm_pkg::ID_W-1:0]    slave_id; // last broadcast id
    logic                         id_valid;
    logic [wadm_pkg::DATA_W-1:0]  rdata;
    logic                         rsp_valid;
    logic                         ready;
    logic [3:0]                   be_n;
    logic                         ads_n;
    wadm_pkg::wadm_bufen_type     bufen;
    logic [wadm_pkg::DATA_W-1:0]  ad_o;
    logic                         ad_oe;
    logic                         slave_processor_strobe;
    logic                         tgt_ads_n;
    logic                         cpu_hold_acknowledge;
  } wadm_regs_type;

  wadm_regs_type q_r;    // registered state
  wadm_regs_type q_nxt;  // next state

  logic wr_dly;   // delayed write data phase
  logic spc_dly;  // delayed slave strobe request
  logic wr_req;   // write data phase wanted
  logic spc_req;  // slave strobe wanted

  // decode of the cycle in hand
  logic is_mem;
  logic is_slv;
  logic is_wr_kind;
  logic slv_rd_ok;
  logic [3:0] lanes;
  logic hi_lane;
  logic [wadm_pkg::NARROW_W-1:0] wr_half;

  always_comb begin
    is_mem = (q_r.req.kind == wadm_pkg::KIND_MEM_RD) |
             (q_r.req.kind == wadm_pkg::KIND_MEM_WR);
    is_slv = ~is_mem;
    is_wr_kind = (q_r.req.kind == wadm_pkg::KIND_MEM_WR) |
                 (q_r.req.kind == wadm_pkg::KIND_SLV_WR) |
                 (q_r.req.kind == wadm_pkg::KIND_SLV_ID);
    // slave reads open buffers only for a known non-mmu slave
    slv_rd_ok = SLAVE_ACCESS & q_r.id_valid &
                (q_r.slave_id != MMU_SLAVE_ID);
    lanes = wadm_pkg::lane_mask(q_r.req.addr[1:0],
                                wadm_pkg::eff_size(q_r.req.size));
    hi_lane = q_r.req.addr[wadm_pkg::HI_LANE_BIT];
    wr_half = q_r.second ? q_r.req.wdata[wadm_pkg::DATA_W-1:wadm_pkg::NARROW_W]
                         : q_r.req.wdata[wadm_pkg::NARROW_W-1:0];
  end

  // requests to the two delay lines
  always_comb begin
    wr_req = ((q_r.st == wadm_pkg::ST_T2) | (q_r.st == wadm_pkg::ST_T3)) &
             (q_r.req.kind == wadm_pkg::KIND_MEM_WR);
    // strobe waits until the cpu shows the expected direction
    spc_req = ((q_r.st == wadm_pkg::ST_T2) | (q_r.st == wadm_pkg::ST_T3)) & is_slv &
              (DATA_DIRECTION_IN == ~is_wr_kind);
  end

  // write enable delay
  wadm_delay #(.DEPTH(WR_DELAY)) u_write_enable_delay (
    .clk_sys (CLK_SYS),
    .rst     (RST),
    .lvl_in  (wr_req),
    .lvl_out (wr_dly)
  );

  // slave strobe delay
  wadm_delay #(.DEPTH(SPC_DELAY)) u_strobe_delay (
    .clk_sys (CLK_SYS),
    .rst     (RST),
    .lvl_in  (spc_req),
    .lvl_out (spc_dly)
  );

  // bus sequencer and registered outputs
  always_comb begin
    logic data_ok;
    logic done;
    logic lo_on;
    logic hi_on;
    data_ok = 1'b0;
    done = 1'b0;
    lo_on = 1'b0;
    hi_on = 1'b0;
    q_nxt = q_r;
    q_nxt.rsp_valid = 1'b0;
    // a cycle in t3 ends once its data buffer or strobe has been on
    done = is_slv ? q_r.slave_processor_strobe : (q_r.bufen.data_lo_oe | q_r.bufen.data_hi_oe);
    unique case (q_r.st)
      wadm_pkg::ST_IDLE: begin
        if (REQ_VALID & q_r.ready) begin
          q_nxt.req = REQ;
          q_nxt.second = 1'b0;
          q_nxt.st = wadm_pkg::ST_T1;
          // broadcast id kept for later slave reads
          if (REQ.kind == wadm_pkg::KIND_SLV_ID) begin
            q_nxt.slave_id = REQ.wdata[wadm_pkg::ID_W-1:0];
            q_nxt.id_valid = 1'b1;
          end
        end
      end
      wadm_pkg::ST_T1: begin
        q_nxt.st = wadm_pkg::ST_T2;
      end
      wadm_pkg::ST_T2: begin
        q_nxt.st = wadm_pkg::ST_T3;
      end
      wadm_pkg::ST_T3: begin
        if (done) begin
          q_nxt.st = wadm_pkg::ST_T4;
        end
        // capture the read half as soon as its buffer is open
        if (~is_wr_kind & (q_r.bufen.data_lo_oe | q_r.bufen.data_hi_oe)) begin
          if (q_r.second) begin
            q_nxt.rdata[wadm_pkg::DATA_W-1:wadm_pkg::NARROW_W] =
              hi_lane ? TGT_AD_I[wadm_pkg::DATA_W-1:wadm_pkg::NARROW_W]
                      : TGT_AD_I[wadm_pkg::NARROW_W-1:0];
          end else begin
            q_nxt.rdata[wadm_pkg::NARROW_W-1:0] =
              (hi_lane & is_mem) ? TGT_AD_I[wadm_pkg::DATA_W-1:wadm_pkg::NARROW_W]
                                 : TGT_AD_I[wadm_pkg::NARROW_W-1:0];
          end
        end
      end
      wadm_pkg::ST_T4: begin
        // doubleword: go round again for the upper halfword
        if (is_mem & (q_r.req.size == wadm_pkg::SIZE_DWORD) & ~q_r.second) begin
          q_nxt.second = 1'b1;
          q_nxt.req.addr = q_r.req.addr + wadm_pkg::HALF_STEP;
          q_nxt.st = wadm_pkg::ST_T1;
        end else begin
          q_nxt.rsp_valid = 1'b1;
          q_nxt.st = wadm_pkg::ST_IDLE;
        end
      end
    endcase
    q_nxt.ready = (q_nxt.st == wadm_pkg::ST_IDLE) & ~(REQ_VALID & q_r.ready);

    // data buffers open only in t3, writes only after the delay line
    // slave reads wait for the strobe, so a late direction cannot open them
    unique case (q_r.req.kind)
      wadm_pkg::KIND_MEM_RD: data_ok = 1'b1;
      wadm_pkg::KIND_MEM_WR: data_ok = wr_dly;
      wadm_pkg::KIND_SLV_RD: data_ok = slv_rd_ok & spc_dly;
      default:               data_ok = 1'b0;
    endcase
    // the swap buffer is held back past t2, when the upper address turns off
    lo_on = (q_nxt.st == wadm_pkg::ST_T3) & (q_r.st == wadm_pkg::ST_T3) & data_ok &
            (is_slv | ~hi_lane);
    hi_on = (q_nxt.st == wadm_pkg::ST_T3) & (q_r.st == wadm_pkg::ST_T3) & data_ok &
            is_mem & hi_lane;
    q_nxt.bufen.data_lo_oe = lo_on;
    q_nxt.bufen.data_hi_oe = hi_on;
    // upper address only through t1 of a memory cycle, never idle or slave
    q_nxt.bufen.addr_hi_oe = (q_nxt.st == wadm_pkg::ST_T1) & is_mem &
                             (q_r.st != wadm_pkg::ST_IDLE);
    if ((q_r.st == wadm_pkg::ST_IDLE) & (q_nxt.st == wadm_pkg::ST_T1)) begin
      q_nxt.bufen.addr_hi_oe = (REQ.kind == wadm_pkg::KIND_MEM_RD) |
                               (REQ.kind == wadm_pkg::KIND_MEM_WR);
    end
    q_nxt.ads_n = ~q_nxt.bufen.addr_hi_oe;

    // byte enables follow the lanes of a memory cycle, all off in slave cycles
    if ((q_nxt.st != wadm_pkg::ST_IDLE) & (q_nxt.st != wadm_pkg::ST_T1) & is_mem) begin
      q_nxt.be_n = ~lanes;
    end else if (q_nxt.st == wadm_pkg::ST_T1 & q_nxt.bufen.addr_hi_oe) begin
      q_nxt.be_n = ~wadm_pkg::lane_mask(q_nxt.req.addr[1:0],
                                        wadm_pkg::eff_size(q_nxt.req.size));
    end else begin
      q_nxt.be_n = wadm_pkg::BE_IDLE_N;
    end

    // address in t1, write half copied onto both halves after
    if (q_nxt.bufen.addr_hi_oe) begin
      q_nxt.ad_o = {wadm_pkg::ADDR_PAD, q_nxt.req.addr};
    end else begin
      q_nxt.ad_o = {wr_half, wr_half};
    end
    q_nxt.ad_oe = q_nxt.bufen.addr_hi_oe |
                  ((q_r.req.kind == wadm_pkg::KIND_MEM_WR) & (lo_on | hi_on));

    q_nxt.slave_processor_strobe = spc_dly & (q_r.st == wadm_pkg::ST_T3);
    // strobe and hold ack follow the mmu when it is strapped in
    q_nxt.tgt_ads_n = MMU_ROUTE ? PHYSICAL_ADDRESS_VALID_N : q_nxt.ads_n;
    q_nxt.cpu_hold_acknowledge = MMU_ROUTE ? MMU_HOLD_ACK_OUT : EMU_HOLD_ACK;
  end

  // register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q_r <= '0;
      q_r.be_n <= wadm_pkg::BE_IDLE_N;
      q_r.ads_n <= 1'b1;
      q_r.tgt_ads_n <= 1'b1;
      q_r.ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from the state flops
  assign REQ_READY = q_r.ready;
  assign RSP_VALID = q_r.rsp_valid;
  assign RSP_RDATA = q_r.rdata;
  assign TGT_AD_O = q_r.ad_o;
  assign TGT_AD_OE = q_r.ad_oe;
  assign BYTE_LANE_ENABLE_N = q_r.be_n;
  assign BUF_EN = q_r.bufen;
  assign SLAVE_PROCESSOR_STROBE = q_r.slave_processor_strobe;
  assign CPU_ADDRESS_STROBE_N = q_r.tgt_ads_n;
  assign CPU_HOLD_ACKNOWLEDGE = q_r.cpu_hold_acknowledge;

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  narrow_lanes_a: assert property (~(&q_r.be_n) |-> $countones(~q_r.be_n) <= 2)
    else $error("more than two byte lanes enabled");
  dword_split_a: assert property (
      (q_r.st == wadm_pkg::ST_T4) & is_mem & (q_r.req.size == wadm_pkg::SIZE_DWORD) &
      ~q_r.second |=> (q_r.st == wadm_pkg::ST_T1) & q_r.second & ~q_r.rsp_valid)
    else $error("doubleword not split into two cycles");
  lane_enables_a: assert property (
      (q_r.st == wadm_pkg::ST_T3) & is_mem |-> q_r.be_n == ~lanes)
    else $error("byte enables do not match lanes");
  mmu_read_off_a: assert property (
      (q_r.req.kind == wadm_pkg::KIND_SLV_RD) & (q_r.slave_id == MMU_SLAVE_ID) |->
      ~q_r.bufen.data_lo_oe & ~q_r.bufen.data_hi_oe)
    else $error("data buffer open on mmu slave read");
  slave_id_a: assert property (
      (q_r.st == wadm_pkg::ST_IDLE) & q_r.ready & REQ_VALID &
      (REQ.kind == wadm_pkg::KIND_SLV_ID) |=> q_r.slave_id == $past(REQ.wdata[7:0]))
    else $error("slave id not captured");
  idle_off_a: assert property (
      (q_r.st == wadm_pkg::ST_IDLE) | is_slv |-> ~q_r.bufen.addr_hi_oe)
    else $error("address buffer open in idle or slave cycle");
  write_delay_a: assert property (
      $rose(q_r.st == wadm_pkg::ST_T2) & (q_r.req.kind == wadm_pkg::KIND_MEM_WR) |->
      ~(q_r.bufen.data_lo_oe | q_r.bufen.data_hi_oe) [*2])
    else $error("write buffer enabled without delay");
  swap_after_addr_a: assert property (
      q_r.bufen.data_hi_oe |-> ~q_r.bufen.addr_hi_oe & $past(~q_r.bufen.addr_hi_oe))
    else $error("swap buffer overlaps upper address");
  strobe_dir_a: assert property (
      $rose(q_r.slave_processor_strobe) |-> $past(DATA_DIRECTION_IN, 2) == ~is_wr_kind)
    else $error("slave strobe before direction valid");
  slave_buf_strobe_a: assert property (is_slv & q_r.bufen.data_lo_oe |-> q_r.slave_processor_strobe)
    else $error("slave data buffer open without strobe");
  route_a: assert property (
      MMU_ROUTE |=> CPU_ADDRESS_STROBE_N == $past(PHYSICAL_ADDRESS_VALID_N) &&
      CPU_HOLD_ACKNOWLEDGE == $past(MMU_HOLD_ACK_OUT))
    else $error("mmu strobe or hold not routed");
  mem_done_a: assert property (
      $rose(q_r.st == wadm_pkg::ST_T1) |-> ##[1:40] (q_r.st == wadm_pkg::ST_T4))
    else $error("memory cycle did not finish");

  dword_read_c: cover property (
      q_r.rsp_valid & (q_r.req.size == wadm_pkg::SIZE_DWORD) &
      (q_r.req.kind == wadm_pkg::KIND_MEM_RD));
  half_write_c: cover property (q_r.bufen.data_hi_oe & (q_r.req.kind == wadm_pkg::KIND_MEM_WR));
  slave_read_c: cover property (q_r.bufen.data_lo_oe & (q_r.req.kind == wadm_pkg::KIND_SLV_RD));
  mmu_route_c: cover property (MMU_ROUTE & ~CPU_ADDRESS_STROBE_N);

endmodule
`default_nettype wire

// ===== testbench/wadm_target_model.sv
// wadm_target_model: target memory behind the adapter's multiplexed bus
// assumes the adapter drives the address in the cycle its upper address buffer is on
`timescale 1ns/1ps
`default_nettype none
module wadm_target_model (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // adapter side of the target bus
  input  wire logic [31:0]              ad_o,
  input  wire logic                     ad_oe,
  input  wire logic [3:0]               be_n,
  input  wire wadm_pkg::wadm_bufen_type buf_en,
  output var  logic [31:0]              ad_i
);
  logic [31:0] mem [logic [21:0]];  // written words only
  logic [21:0] word_r;              // word latched at the address phase
  logic [31:0] noise_r;             // stale-bus pattern, flips every cycle
  logic        den;                 // a data buffer is open

  assign den = buf_en.data_lo_oe | buf_en.data_hi_oe;

  // unwritten words read back a pattern made from their address
  function automatic logic [31:0] rd(input logic [21:0] w);
    return mem.exists(w) ? mem[w] : {w[15:0] ^ 16'hc3a5, ~w[15:0]};
  endfunction

  // data only while a buffer is open and the adapter is not driving
  assign ad_i = (den && !ad_oe) ? rd(word_r) : noise_r;

  // latch address, store enabled byte lanes of write data
  always @(posedge clk_sys or posedge rst) begin
    logic [31:0] w;
    if (rst) begin
      noise_r <= 32'h5a5a_a5a5;
    end else begin
      noise_r <= ~noise_r;
      if (ad_oe && buf_en.addr_hi_oe) begin
        word_r <= ad_o[23:2];
      end else if (ad_oe && den) begin
        w = rd(word_r);
        for (int i = 0; i < 4; i++) begin
          if (!be_n[i]) w[8*i +: 8] = ad_o[8*i +: 8];
        end
        mem[word_r] = w;
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/wadm_top_tb.sv
// wadm_top_tb: self-checking bench, scoreboard of expected answers
// assumes the target model stands behind the adapter's target bus
`timescale 1ns/1ps
`default_nettype none
module wadm_top_tb;
  localparam logic [7:0] MMU_ID  = 8'h3c;  // arbitrary value
  localparam int         TIMEOUT = 6000;   // cycles, far above the planned run

  // one expected answer
  typedef struct {
    logic [31:0] data;
    int          passes;
    logic        rd, full, need_lo;
  } wadm_note_type;

  logic clk_sys, rst, req_valid, req_ready, rsp_valid, ad_oe, data_direction_in, strobe;
  logic route, pav_n, mmu_hold, emu_hold, ads_n, hold;
  wadm_pkg::wadm_req_type   req;
  wadm_pkg::wadm_bufen_type buf_en;
  logic [31:0] rsp_rdata, ad_i, ad_o;
  logic [31:0] noise_r = 32'h0000_0055;  // lfsr state, seeded at 85
  logic [3:0]  be_n;
  wadm_pkg::wadm_kind_type cur_kind;  // kind of the cycle in flight
  wadm_pkg::wadm_size_type cur_size;
  logic [23:0] cur_addr;
  logic [7:0]  cur_id, slv_id;        // slave id in effect
  logic [31:0] exp_mem [logic [21:0]];
  wadm_note_type notes [$];
  int error_cnt, checks_done, take_cnt, rsp_cnt, cyc;

  wadm_top #(.MMU_SLAVE_ID(MMU_ID), .WR_DELAY(2)) i_dut (
    .CLK_SYS(clk_sys), .RST(rst), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .TGT_AD_I(ad_i), .TGT_AD_O(ad_o),
    .TGT_AD_OE(ad_oe), .BYTE_LANE_ENABLE_N(be_n), .BUF_EN(buf_en),
    .DATA_DIRECTION_IN(data_direction_in), .SLAVE_PROCESSOR_STROBE(strobe), .MMU_ROUTE(route),
    .PHYSICAL_ADDRESS_VALID_N(pav_n), .MMU_HOLD_ACK_OUT(mmu_hold),
    .EMU_HOLD_ACK(emu_hold), .CPU_ADDRESS_STROBE_N(ads_n), .CPU_HOLD_ACKNOWLEDGE(hold));

  wadm_target_model i_tgt (.clk_sys(clk_sys), .rst(rst), .ad_o(ad_o), .ad_oe(ad_oe),
    .be_n(be_n), .buf_en(buf_en), .ad_i(ad_i));

  always #5 clk_sys = ~clk_sys;

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // lanes of one narrow cycle, worked out on its own
  function automatic logic [3:0] lanes(input logic [1:0] a, input wadm_pkg::wadm_size_type s);
    return (s == wadm_pkg::SIZE_BYTE) ? 4'h1 << a : 4'h3 << {a[1], 1'b0};
  endfunction

  function automatic logic [31:0] exp_rd(input logic [21:0] w);
    return exp_mem.exists(w) ? exp_mem[w] : {w[15:0] ^ 16'hc3a5, ~w[15:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // offer, wait for take, note the answer; late holds the direction wrong 3 cycles
  task automatic issue(input wadm_pkg::wadm_req_type r, input bit late);
    wadm_note_type n;
    logic [31:0] w;
    logic [3:0] m;
    logic dir;
    logic [31:0] d;  // write data as it lands on the lanes
    req_valid <= 1'b1;
    req <= r;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    dir = r.kind inside {wadm_pkg::KIND_MEM_RD, wadm_pkg::KIND_SLV_RD};
    w = exp_rd(r.addr[23:2]);
    n.full = (r.size == wadm_pkg::SIZE_DWORD);
    m = n.full ? 4'hf : lanes(r.addr[1:0], r.size);
    n.rd = (r.kind == wadm_pkg::KIND_MEM_RD);
    n.data = n.full ? w : {16'h0000, w[16*r.addr[1] +: 16]};
    n.passes = (r.kind > wadm_pkg::KIND_MEM_WR) ? 0 : (n.full ? 2 : 1);
    n.need_lo = (r.kind == wadm_pkg::KIND_SLV_RD) && (slv_id != MMU_ID);
    // a narrow write carries its halfword in wdata[15:0], shown on both halves
    d = n.full ? r.wdata : {2{r.wdata[15:0]}};
    if (r.kind == wadm_pkg::KIND_MEM_WR) begin
      for (int i = 0; i < 4; i++) if (m[i]) w[8*i +: 8] = d[8*i +: 8];
      exp_mem[r.addr[23:2]] = w;
    end
    if (r.kind == wadm_pkg::KIND_SLV_ID) slv_id = r.wdata[7:0];
    notes.push_back(n);
    cur_kind <= r.kind;
    cur_size <= r.size;
    cur_addr <= r.addr;
    cur_id <= slv_id;
    take_cnt <= take_cnt + 1;
    data_direction_in <= late ? !dir : dir;
    if (late) begin
      req_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
      data_direction_in <= dir;
    end
  endtask

  // answer monitor and per-cycle port checks
  always @(posedge clk_sys) begin
    static int passes = 0, t1_cnt = 0;
    static logic aho_q = 0, den_q = 0, saw_lo = 0, armed = 0, p_rt, p_pav, p_mh, p_eh;
    wadm_note_type n;
    logic [23:0] pa;
    logic busy, den, slv;
    busy = (take_cnt != rsp_cnt);
    den = buf_en.data_lo_oe | buf_en.data_hi_oe;
    slv = busy && (cur_kind > wadm_pkg::KIND_MEM_WR);
    if (!rst && armed) begin
      if (!busy) chk(32'(buf_en), 32'h0);
      if (buf_en.data_hi_oe) chk({buf_en.addr_hi_oe, aho_q}, 32'h0);
      if (slv) chk({be_n, buf_en.addr_hi_oe}, 32'h1e);
      if (slv && cur_kind == wadm_pkg::KIND_SLV_RD && cur_id == MMU_ID) chk(32'(den), 0);
      if (slv && cur_kind == wadm_pkg::KIND_SLV_RD && buf_en.data_lo_oe) saw_lo = 1'b1;
      if (strobe) chk(32'(data_direction_in), 32'(cur_kind == wadm_pkg::KIND_SLV_RD));
      if (slv && den) chk(32'(strobe), 1);
      if (busy && cur_kind == wadm_pkg::KIND_MEM_WR && den && !den_q) chk(32'(t1_cnt >= 4), 1);
      if (buf_en.addr_hi_oe && !aho_q) begin
        pa = cur_addr + 24'(2 * passes);
        chk(32'(ad_o[23:0]), 32'(pa));
        chk({28'h0, ~be_n}, 32'(lanes(pa[1:0], cur_size)));
        passes++;
      end
      if (p_rt) chk(32'(ads_n), 32'(p_pav));
      else chk(32'(ads_n), 32'(!buf_en.addr_hi_oe));
      chk(32'(hold), 32'(p_rt ? p_mh : p_eh));
      if (rsp_valid) begin
        if (notes.size() == 0) begin
          chk(32'(rsp_valid), 32'h0);
        end else begin
          n = notes.pop_front();
          chk(passes, n.passes);
          if (n.rd) chk(n.full ? rsp_rdata : {16'h0000, rsp_rdata[15:0]}, n.data);
          if (n.need_lo) chk(32'(saw_lo), 1);
        end
        passes = 0;
        saw_lo = 0;
        rsp_cnt <= rsp_cnt + 1;
      end
    end
    t1_cnt = buf_en.addr_hi_oe ? 0 : t1_cnt + 1;
    {aho_q, den_q, armed} = {buf_en.addr_hi_oe, den, !rst};
    {p_rt, p_pav, p_mh, p_eh} = {route, pav_n, mmu_hold, emu_hold};
  end

  // random hold and address-valid sources, a hang limit
  always @(posedge clk_sys) begin
    noise_r <= 32'(lfsr_next(noise_r[15:0]));
    {pav_n, mmu_hold, emu_hold} <= {noise_r[0], noise_r[3], noise_r[7]};
    cyc++;
    if (cyc == TIMEOUT) begin
      error_cnt++;
      summarize();
    end
  end

  // main sequence: random memory traffic, then slave cycles
  initial begin
    logic [15:0] rnd;
    wadm_pkg::wadm_size_type sz;
    logic [1:0] lo;
    {clk_sys, rst, req_valid, data_direction_in, route} = 5'h08;
    req = '0;
    rnd = 16'h0055;
    slv_id = 8'h00;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    for (int k = 0; k < 40; k++) begin
      rnd = lfsr_next(rnd);
      sz = wadm_pkg::wadm_size_type'(rnd[2:1] % 2'h3);
      lo = (sz == wadm_pkg::SIZE_BYTE) ? rnd[7:6] : {rnd[7] & (sz == wadm_pkg::SIZE_HALF), 1'b0};
      route <= rnd[11];
      issue('{kind: rnd[0] ? wadm_pkg::KIND_MEM_WR : wadm_pkg::KIND_MEM_RD, size: sz,
              addr: {16'h0040, 3'h0, rnd[5:3], lo},
              wdata: (sz == wadm_pkg::SIZE_BYTE) ? {4{rnd[15:8]}} : {rnd, lfsr_next(rnd)}
                     & ((sz == wadm_pkg::SIZE_HALF) ? 32'h0000_ffff : 32'hffff_ffff)
                     | ((sz == wadm_pkg::SIZE_HALF) ? {rnd, 16'h0000} : 32'h0)}, 1'b0);
    end
    issue('{wadm_pkg::KIND_SLV_ID, wadm_pkg::SIZE_BYTE, 24'h0, {24'h0, MMU_ID}}, 1'b0);
    issue('{wadm_pkg::KIND_SLV_RD, wadm_pkg::SIZE_HALF, 24'h0, 32'h0}, 1'b1);
    issue('{wadm_pkg::KIND_SLV_WR, wadm_pkg::SIZE_HALF, 24'h0, 32'h1234_5678}, 1'b1);
    issue('{wadm_pkg::KIND_SLV_ID, wadm_pkg::SIZE_BYTE, 24'h0, 32'h0000_0011}, 1'b0);
    issue('{wadm_pkg::KIND_SLV_RD, wadm_pkg::SIZE_HALF, 24'h0, 32'h0}, 1'b1);
    req_valid <= 1'b0;
    @(posedge clk_sys);
    for (int t = 0; t < 300 && take_cnt != rsp_cnt; t++) @(posedge clk_sys);
    chk(rsp_cnt, take_cnt);
    summarize();
  end
endmodule
`default_nettype wire
